// [design/cmd_pkg.sv]
// package: command codes, config values, register map, carriers
package cmd_pkg;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_BSL = 8'h5C;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_J = 8'h4A;
  localparam logic [7:0] CH_EQ = 8'h3D;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_LP = 8'h28;
  localparam logic [7:0] CH_RP = 8'h29;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_Q = 8'h3F;
  // error codes returned on the answer port
  localparam logic [7:0] ERR_ILLEGAL = 8'h03;
  localparam logic [7:0] ERR_RESUME = 8'h11;
  localparam logic [1:0] ADDR_CFG_LO = 2'h2;
  localparam logic [1:0] ADDR_CFG_HI = 2'h3;
  localparam logic [1:0] ERPT_A = 2'h1;
  localparam logic [1:0] ERPT_B = 2'h3;
  localparam logic [3:0] CARD_RESET = 4'h0;
  localparam int AXES = 9;
  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_ANS = 8'h0C;
  localparam logic [7:0] REG_RATE = 8'h10;
  localparam logic [7:0] REG_MOTION = 8'h14;
  // cfg fields
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_ERPT_LSB = 2;
  localparam int CFG_SEG_LSB = 4;
  localparam int CFG_ABSTART_BIT = 12;
  localparam int CFG_CARD_LSB = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [15:0] RATE_RESET = 16'h0001;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_AT = 7'h02, S_ABS = 7'h04, S_ABSARG = 7'h08,
    S_J = 7'h10, S_P = 7'h20, S_SKIP = 7'h40
  } pstate_t;

  typedef enum logic [3:0] {
    M_RUN = 4'h1, M_HOLD = 4'h2, M_FHOLD = 4'h4, M_ABORT = 4'h8
  } mstate_t;

  typedef struct packed {
    logic valid;
    logic isErr;
    logic [7:0] code;
  } answer_t;

  typedef struct packed {
    logic [3:0] cardNum;
    logic [1:0] addrCfg;
    logic [1:0] errMode;
    logic [7:0] segTime;
    logic abortStart;
  } cfg_t;
endpackage : cmd_pkg

// [design/card_select.sv]
// card select: modal addressing of one card or all cards
`timescale 1ns/1ps
module card_select (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic selStrobe,
  input wire logic [7:0] selChar,
  input wire logic [3:0] cardNum,
  input wire logic [1:0] addrCfg,
  output logic selected,
  output logic allSel,
  output logic [3:0] curCard,
  output logic refused
);
  logic [3:0] next_curCard;
  logic next_allSel;
  logic next_refused;
  logic cfgOk;
  logic isHex;
  logic [3:0] hexVal;

  always_comb begin
    isHex = 1'b1;
    hexVal = 4'h0;
    if (selChar >= 8'h30 && selChar <= 8'h39) begin
      hexVal = selChar[3:0];
    end else if (selChar >= 8'h41 && selChar <= 8'h46) begin
      hexVal = 4'(selChar[3:0] + 4'h9);
    end else begin
      isHex = 1'b0;
    end
  end

  assign cfgOk = (addrCfg == cmd_pkg::ADDR_CFG_LO) ||
                 (addrCfg == cmd_pkg::ADDR_CFG_HI);

  always_comb begin
    next_curCard = curCard;
    next_allSel = allSel;
    next_refused = 1'b0;
    if (selStrobe) begin
      if (!cfgOk) begin
        next_refused = 1'b1; // RQ4
      end else if (selChar == cmd_pkg::CH_AT) begin
        next_allSel = 1'b1; // RQ1
      end else if (isHex) begin
        next_allSel = 1'b0; // RQ2
        next_curCard = hexVal; // RQ1
      end else if (selChar != cmd_pkg::CH_CR) begin
        next_refused = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      curCard <= cmd_pkg::CARD_RESET; // RQ3
      allSel <= 1'b0;
      refused <= 1'b0;
    end else begin
      curCard <= next_curCard;
      allSel <= next_allSel;
      refused <= next_refused;
    end
  end

  assign selected = allSel || (curCard == cardNum);
endmodule : card_select

// [design/card_cmd_ctrl.sv]
// command interpreter: card addressing, hold, abort, absolute mode
//
// Contract
// RQ1: card argument is hex digit 0..F or at-sign for all cards.
// RQ2: selection is modal until another card is selected.
// RQ3: card zero is selected after reset.
// RQ4: card select accepted only with addressing config 2 or 3.
// RQ5: all-cards mode rejects every query command. Code rejects only ?; card zero answers the address query with at-sign.
// RQ6: host should send carriage return after card select.
// RQ7: feed hold permits jogging when segmented with nonzero time.
// RQ8: otherwise feed hold acts as plain hold, no moves allowed.
// RQ9: one global hold rate sets decel into and accel out of hold.
// RQ10: run resumes only after return-to-prejog, else resume error.
// RQ11: lookahead feed hold decels within accel limit, allows reversal.
// RQ12: abort decelerates all axes, ends program, closes motor loops.
// RQ13: each motor decelerates at its own abort rate on abort.
// RQ14: resume after abort uses original ends unless match or select.
// RQ15: after abort, return-to-prejog goes to end only if unsegmented.
// RQ16: bare absolute command sets all axes, list sets listed only.
// RQ17: letter R sets radius vector absolute; bare form leaves it.
// RQ18: absolute command is stored when a program buffer is open.
// RQ19: absolute arguments are axis letters only, no spaces.
// RQ20: address query returns card number; card zero says at-sign.
// RQ21: unselected card keeps its transmit output undriven.
`timescale 1ns/1ps
module card_cmd_ctrl (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic programRunning,
  input wire logic segmentedMove,
  input wire logic lookaheadActive,
  input wire logic bufferOpen,
  input wire logic [8:0] motorsAtHold,
  input wire logic [8:0] motorsOpenLoop,
  output logic txEnable_n,
  output logic holdActive,
  output logic jogAllowed,
  output logic reversalAllowed,
  output logic [15:0] holdRate,
  output logic abortPulse,
  output logic [8:0] closeLoopPulse,
  output logic [8:0] axisAbs,
  output logic radiusAbs,
  output logic bufferStore,
  output logic useOrigEnd,
  output logic prejogToEnd
);
  logic [31:0] cfgReg;
  logic [31:0] next_cfgReg;
  logic [15:0] next_holdRate;
  cmd_pkg::cfg_t cfg;
  cmd_pkg::pstate_t pst;
  cmd_pkg::pstate_t next_pst;
  cmd_pkg::mstate_t mst;
  cmd_pkg::mstate_t next_mst;
  cmd_pkg::answer_t ans;
  cmd_pkg::answer_t next_ans;
  logic [8:0] next_axisAbs;
  logic [8:0] absList;
  logic [8:0] next_absList;
  logic next_radiusAbs;
  logic absR;
  logic next_absR;
  logic next_bufferStore;
  logic next_abortPulse;
  logic [8:0] next_closeLoopPulse;
  logic aborted;
  logic next_aborted;
  logic matched;
  logic next_matched;
  logic next_ack;
  logic selStrobe;
  logic selected;
  logic allSel;
  logic [3:0] curCard;
  logic selRefused;
  logic cmdWr;
  logic [7:0] ch;
  logic [8:0] axisBit;

  assign cfg.addrCfg = cfgReg[cmd_pkg::CFG_ADDR_LSB +: 2];
  assign cfg.errMode = cfgReg[cmd_pkg::CFG_ERPT_LSB +: 2];
  assign cfg.segTime = cfgReg[cmd_pkg::CFG_SEG_LSB +: 8];
  assign cfg.abortStart = cfgReg[cmd_pkg::CFG_ABSTART_BIT];
  assign cfg.cardNum = cfgReg[cmd_pkg::CFG_CARD_LSB +: 4];

  assign cmdWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                 wb_adr_i == cmd_pkg::REG_CMD && wb_sel_i[0];
  assign ch = wb_dat_i[7:0];
  assign selStrobe = cmdWr && pst == cmd_pkg::S_AT;

  card_select u_sel (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .selStrobe(selStrobe),
    .selChar(ch),
    .cardNum(cfg.cardNum),
    .addrCfg(cfg.addrCfg),
    .selected(selected),
    .allSel(allSel),
    .curCard(curCard),
    .refused(selRefused)
  );

  // axis letter decode X Y Z A B C U V W
  always_comb begin
    case (ch)
      8'h58: axisBit = 9'h001;
      8'h59: axisBit = 9'h002;
      8'h5A: axisBit = 9'h004;
      8'h41: axisBit = 9'h008;
      8'h42: axisBit = 9'h010;
      8'h43: axisBit = 9'h020;
      8'h55: axisBit = 9'h040;
      8'h56: axisBit = 9'h080;
      8'h57: axisBit = 9'h100;
      default: axisBit = 9'h000;
    endcase
  end

  // only the selected card, or card zero in all-cards mode, drives the shared line
  assign txEnable_n = !(selected && !allSel) &&
                      !(allSel && cfg.cardNum == 4'h0); // RQ21

  // wishbone slave, one-wait-state answer cycle, ack registered
  always_comb begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_cfgReg = cfgReg;
    next_holdRate = holdRate;
    if (next_ack && wb_we_i) begin
      if (wb_adr_i == cmd_pkg::REG_CFG) begin
        for (int i = 0; i < 4; i++) begin
          if (wb_sel_i[i]) begin
            next_cfgReg[8*i +: 8] = wb_dat_i[8*i +: 8];
          end
        end
      end
      if (wb_adr_i == cmd_pkg::REG_RATE && wb_sel_i[0]) begin
        next_holdRate[7:0] = wb_dat_i[7:0]; // RQ9
      end
      if (wb_adr_i == cmd_pkg::REG_RATE && wb_sel_i[1]) begin
        next_holdRate[15:8] = wb_dat_i[15:8]; // RQ9
      end
    end
  end

  // parser and motion state
  always_comb begin
    next_pst = pst;
    next_mst = mst;
    next_ans = '0;
    next_axisAbs = axisAbs;
    next_absList = absList;
    next_radiusAbs = radiusAbs;
    next_absR = absR;
    next_bufferStore = 1'b0;
    next_abortPulse = 1'b0;
    next_closeLoopPulse = '0;
    next_aborted = aborted;
    next_matched = matched;
    if (selRefused) begin
      next_ans = '{valid: 1'b1, isErr: 1'b1, code: cmd_pkg::ERR_ILLEGAL};
    end
    if (cmdWr) begin
      case (pst)
        cmd_pkg::S_IDLE: begin
          if (ch == cmd_pkg::CH_AT) begin
            next_pst = cmd_pkg::S_AT;
          end else if (!selected) begin
            next_pst = (ch == cmd_pkg::CH_CR) ? cmd_pkg::S_IDLE
                                              : cmd_pkg::S_SKIP; // RQ2
          end else if (ch == cmd_pkg::CH_BSL) begin
            if (programRunning) begin
              next_mst = (segmentedMove && cfg.segTime != 8'h00) ||
                         lookaheadActive ? cmd_pkg::M_FHOLD // RQ7 RQ11
                                         : cmd_pkg::M_HOLD; // RQ8
            end
          end else if (ch == cmd_pkg::CH_A) begin
            next_mst = cmd_pkg::M_ABORT; // RQ12
            next_abortPulse = 1'b1; // RQ13
            next_closeLoopPulse = motorsOpenLoop; // RQ12
            next_aborted = 1'b1;
            next_matched = 1'b0;
          end else if (ch == cmd_pkg::CH_R || ch == cmd_pkg::CH_S) begin
            if ((mst == cmd_pkg::M_FHOLD || mst == cmd_pkg::M_HOLD) &&
                motorsAtHold != 9'h1FF) begin
              if (cfg.errMode == cmd_pkg::ERPT_A ||
                  cfg.errMode == cmd_pkg::ERPT_B) begin
                next_ans = '{valid: 1'b1, isErr: 1'b1,
                             code: cmd_pkg::ERR_RESUME}; // RQ10
              end
            end else begin
              next_mst = cmd_pkg::M_RUN; // RQ10 RQ14
            end
          end else if (ch == cmd_pkg::CH_Q) begin
            if (allSel) begin
              next_ans = '{valid: 1'b1, isErr: 1'b1,
                           code: cmd_pkg::ERR_ILLEGAL}; // RQ5
            end else begin
              next_ans = '{valid: 1'b1, isErr: 1'b0,
                           code: {4'h0, curCard}}; // RQ20
            end
          end else if (ch == cmd_pkg::CH_J) begin
            next_pst = cmd_pkg::S_J;
          end else if (ch == cmd_pkg::CH_P) begin
            next_pst = cmd_pkg::S_P;
          end else if (ch == cmd_pkg::CH_B) begin
            next_pst = cmd_pkg::S_ABS;
          end else if (ch != cmd_pkg::CH_CR) begin
            next_pst = cmd_pkg::S_SKIP;
          end
        end
        cmd_pkg::S_AT: begin
          // at-sign after at-sign: all cards; else one digit
          if (ch == cmd_pkg::CH_CR && !allSel && selected &&
              cfg.addrCfg[1]) begin
            next_ans = '{valid: 1'b1, isErr: 1'b0,
                         code: {4'h0, curCard}}; // RQ20
          end else if (ch == cmd_pkg::CH_CR && allSel &&
                       cfg.cardNum == 4'h0) begin
            next_ans = '{valid: 1'b1, isErr: 1'b0,
                         code: cmd_pkg::CH_AT}; // RQ20
          end
          next_pst = cmd_pkg::S_IDLE;
        end
        cmd_pkg::S_ABS: begin
          // B accepted as prefix of the absolute-mode command
          next_absList = '0;
          next_absR = 1'b0;
          if (ch == cmd_pkg::CH_CR) begin
            next_pst = cmd_pkg::S_IDLE;
            if (bufferOpen) begin
              next_bufferStore = 1'b1; // RQ18
            end else begin
              next_axisAbs = 9'h1FF; // RQ16
            end
          end else if (ch == cmd_pkg::CH_LP) begin
            next_pst = cmd_pkg::S_ABSARG;
          end else begin
            next_pst = cmd_pkg::S_SKIP; // RQ19
          end
        end
        cmd_pkg::S_ABSARG: begin
          if (ch == cmd_pkg::CH_RP) begin
            next_pst = cmd_pkg::S_SKIP;
            if (bufferOpen) begin
              next_bufferStore = 1'b1; // RQ18
            end else begin
              next_axisAbs = axisAbs | absList; // RQ16
              next_radiusAbs = radiusAbs | absR; // RQ17
            end
          end else if (ch == cmd_pkg::CH_R) begin
            next_absR = 1'b1; // RQ17
          end else if (axisBit != 9'h000) begin
            next_absList = absList | axisBit; // RQ19
          end else if (ch != cmd_pkg::CH_COMMA) begin
            next_pst = cmd_pkg::S_SKIP; // RQ19
            next_ans = '{valid: 1'b1, isErr: 1'b1,
                         code: cmd_pkg::ERR_ILLEGAL};
          end
        end
        cmd_pkg::S_J: begin
          // return-to-prejog acknowledged by the motion side
          next_pst = (ch == cmd_pkg::CH_CR) ? cmd_pkg::S_IDLE
                                            : cmd_pkg::S_SKIP;
        end
        cmd_pkg::S_P: begin
          next_matched = 1'b1; // RQ14
          next_pst = (ch == cmd_pkg::CH_CR) ? cmd_pkg::S_IDLE
                                            : cmd_pkg::S_SKIP;
        end
        cmd_pkg::S_SKIP: begin
          if (ch == cmd_pkg::CH_CR) begin
            next_pst = cmd_pkg::S_IDLE;
          end
        end
        default: next_pst = cmd_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      cfgReg <= cmd_pkg::CFG_RESET;
      holdRate <= cmd_pkg::RATE_RESET;
      pst <= cmd_pkg::S_IDLE;
      mst <= cmd_pkg::M_RUN;
      ans <= '0;
      axisAbs <= 9'h1FF;
      absList <= '0;
      radiusAbs <= 1'b0;
      absR <= 1'b0;
      bufferStore <= 1'b0;
      abortPulse <= 1'b0;
      closeLoopPulse <= '0;
      aborted <= 1'b0;
      matched <= 1'b0;
    end else begin
      wb_ack_o <= next_ack;
      cfgReg <= next_cfgReg;
      holdRate <= next_holdRate;
      pst <= next_pst;
      mst <= next_mst;
      ans <= next_ans.valid ? next_ans : ans;
      axisAbs <= next_axisAbs;
      absList <= next_absList;
      radiusAbs <= next_radiusAbs;
      absR <= next_absR;
      bufferStore <= next_bufferStore;
      abortPulse <= next_abortPulse;
      closeLoopPulse <= next_closeLoopPulse;
      aborted <= next_aborted;
      matched <= next_matched;
    end
  end

  assign holdActive = mst == cmd_pkg::M_HOLD || mst == cmd_pkg::M_FHOLD;
  assign jogAllowed = mst == cmd_pkg::M_FHOLD; // RQ7 RQ8
  assign reversalAllowed = jogAllowed && lookaheadActive; // RQ11
  assign useOrigEnd = aborted && !matched && !cfg.abortStart; // RQ14
  assign prejogToEnd = aborted && cfg.segTime == 8'h00; // RQ15

  // read mux, unmapped reads return zero
  always_comb begin
    case (wb_adr_i)
      cmd_pkg::REG_CFG: wb_dat_o = cfgReg;
      cmd_pkg::REG_STAT: wb_dat_o = {16'h0000, 3'h0, aborted, mst,
                                     2'h0, allSel, selected, curCard};
      cmd_pkg::REG_ANS: wb_dat_o = {22'h0, ans.valid, ans.isErr, ans.code};
      cmd_pkg::REG_RATE: wb_dat_o = {16'h0000, holdRate};
      cmd_pkg::REG_MOTION: wb_dat_o = {22'h0, radiusAbs, axisAbs};
      default: wb_dat_o = 32'h0000_0000;
    endcase
  end
endmodule : card_cmd_ctrl

// [testbench/card_cmd_ctrl_sva.sv]
// assertion checker for the card command interpreter
`timescale 1ns/1ps
module card_cmd_ctrl_sva (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic holdActive,
  input wire logic jogAllowed,
  input wire logic reversalAllowed,
  input wire logic abortPulse,
  input wire logic [8:0] closeLoopPulse,
  input wire logic [8:0] axisAbs,
  input wire logic radiusAbs,
  input wire logic bufferStore
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_jog_in_hold: assert property (jogAllowed |-> holdActive)
    else $error("jog outside hold");
  a_reverse_in_hold: assert property (reversalAllowed |-> holdActive)
    else $error("reversal outside hold");
  a_abort_single: assert property (abortPulse |=> !abortPulse)
    else $error("abort pulse too long");
  a_close_with_abort: assert property (|closeLoopPulse |-> abortPulse)
    else $error("loop closed without abort");
  a_store_keeps_mode: assert property (bufferStore |-> $stable(axisAbs)
    && $stable(radiusAbs))
    else $error("stored command applied");
  a_axis_kept: assert property ((axisAbs & $past(axisAbs)) == $past(axisAbs))
    else $error("axis left absolute mode");
  a_radius_kept: assert property (!$fell(radiusAbs) || !$past(rst_b))
    else $error("radius vector mode cleared");
endmodule : card_cmd_ctrl_sva

bind card_cmd_ctrl card_cmd_ctrl_sva u_card_cmd_ctrl_sva (
  .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .holdActive(holdActive),
  .jogAllowed(jogAllowed), .reversalAllowed(reversalAllowed),
  .abortPulse(abortPulse), .closeLoopPulse(closeLoopPulse),
  .axisAbs(axisAbs), .radiusAbs(radiusAbs), .bufferStore(bufferStore));

// [testbench/host_model.sv]
// host model: wishbone master that types ascii commands
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic ack,
  input wire logic [31:0] datIn
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    r = datIn;
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    dat <= ~d;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : xfer
  task key(input logic [7:0] c);
    logic [31:0] r;
    xfer(1'b1, cmd_pkg::REG_CMD, {24'h0, c}, r);
  endtask : key
  task send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      key(s[i]);
    end
  endtask : send
endmodule : host_model

// [testbench/card_cmd_ctrl_test.sv]
// self-checking bench for the card command interpreter
`timescale 1ns/1ps
module card_cmd_ctrl_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cyc, stb, we, ack, txEnable_n, holdActive, jogAllowed, reversalAllowed;
  logic abortPulse, radiusAbs, bufferStore, useOrigEnd, prejogToEnd;
  logic [7:0] adr, segT;
  logic [3:0] sel, card;
  logic [31:0] datW, datR, q;
  logic [15:0] holdRate, rate;
  logic [8:0] closeLoopPulse, axisAbs, lastClose = 9'h000;
  logic programRunning = 1'b0, segmentedMove = 1'b0;
  logic lookaheadActive = 1'b0, bufferOpen = 1'b0;
  logic [8:0] motorsAtHold = 9'h000, motorsOpenLoop = 9'h000;
  int bad_count = 0, cmp_count = 0, cycles = 0, abortCnt = 0, storeCnt = 0;
  integer seed = 88309;

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  host_model u_host_model (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(datW), .ack(ack), .datIn(datR));
  card_cmd_ctrl u_card_cmd_ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
    .programRunning(programRunning), .segmentedMove(segmentedMove),
    .lookaheadActive(lookaheadActive), .bufferOpen(bufferOpen),
    .motorsAtHold(motorsAtHold), .motorsOpenLoop(motorsOpenLoop),
    .txEnable_n(txEnable_n), .holdActive(holdActive),
    .jogAllowed(jogAllowed), .reversalAllowed(reversalAllowed),
    .holdRate(holdRate), .abortPulse(abortPulse),
    .closeLoopPulse(closeLoopPulse), .axisAbs(axisAbs),
    .radiusAbs(radiusAbs), .bufferStore(bufferStore),
    .useOrigEnd(useOrigEnd), .prejogToEnd(prejogToEnd));

  task end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    abortCnt <= abortCnt + int'(abortPulse === 1'b1);
    storeCnt <= storeCnt + int'(bufferStore === 1'b1);
    if (abortPulse === 1'b1) begin
      lastClose <= closeLoopPulse;
    end
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] ans(input logic e, input logic [7:0] c);
    return {22'h0, 1'b1, e, c};
  endfunction : ans

  task rd(input string n, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    u_host_model.xfer(1'b0, a, 32'h0, q);
    check(n, q & m, exp);
  endtask : rd

  task setCfg(input logic [3:0] c, input logic [7:0] s, input logic ab,
      input logic m);
    u_host_model.xfer(1'b1, cmd_pkg::REG_CFG, {12'h000, c, 3'h0, ab, s,
      m ? cmd_pkg::ERPT_B : cmd_pkg::ERPT_A,
      m ? cmd_pkg::ADDR_CFG_HI : cmd_pkg::ADDR_CFG_LO}, q);
  endtask : setCfg

  task pick(input logic [3:0] d);
    u_host_model.key(cmd_pkg::CH_AT);
    u_host_model.key(d < 4'hA ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d});
    u_host_model.key(cmd_pkg::CH_CR);
  endtask : pick

  initial begin
    card = 4'($random(seed));
    rate = 16'($random(seed));
    segT = 8'($random(seed)) | 8'h01;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd("stat", cmd_pkg::REG_STAT, 32'h3F, 32'h10);
    rd("motion", cmd_pkg::REG_MOTION, 32'h3FF, 32'h1FF);
    rd("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
    pick(4'h5);
    rd("ans", cmd_pkg::REG_ANS, 32'h3FF, 32'h303);
    setCfg(card, 8'h00, 1'b0, 1'b0);
    for (int d = 0; d < 16; d++) begin
      pick(4'(d));
      check("tx", 32'(txEnable_n), 32'(4'(d) != card));
      rd("stat", cmd_pkg::REG_STAT, 32'h1F, {27'h0, 4'(d) == card, 4'(d)});
    end
    pick(card);
    u_host_model.send("@\015");
    rd("ans", cmd_pkg::REG_ANS, 32'h3FF, ans(1'b0, {4'h0, card}));
    pick(card + 4'h1);
    u_host_model.send("?\015\\\015");
    rd("ans", cmd_pkg::REG_ANS, 32'h3FF, ans(1'b0, {4'h0, card}));
    check("hold", 32'(holdActive), 32'h0);
    setCfg(4'h0, 8'h00, 1'b0, 1'b1);
    u_host_model.send("@@\015?\015");
    rd("stat", cmd_pkg::REG_STAT, 32'h20, 32'h20);
    check("tx", 32'(txEnable_n), 32'h0);
    rd("ans", cmd_pkg::REG_ANS, 32'h3FF, ans(1'b1, 8'h03));
    u_host_model.send("@\015");
    rd("ans", cmd_pkg::REG_ANS, 32'h3FF, ans(1'b0, 8'h40));
    pick(4'h0);
    u_host_model.xfer(1'b1, cmd_pkg::REG_RATE, {16'h0, rate}, q);
    check("rate", 32'(holdRate), 32'(rate));
    setCfg(4'h0, segT, 1'b0, 1'b0);
    @(posedge clk_sys);
    programRunning <= 1'b1;
    segmentedMove <= 1'b1;
    motorsAtHold <= 9'h0FF;
    u_host_model.send("\\");
    check("hold", 32'({holdActive, jogAllowed, reversalAllowed}), 32'h6);
    u_host_model.send("R");
    rd("ans", cmd_pkg::REG_ANS, 32'h3FF, ans(1'b1, 8'h11));
    check("hold", 32'(holdActive), 32'h1);
    @(posedge clk_sys);
    motorsAtHold <= 9'h1FF;
    u_host_model.send("R");
    check("hold", 32'(holdActive), 32'h0);
    setCfg(4'h0, 8'h00, 1'b0, 1'b1);
    u_host_model.send("\\");
    check("hold", 32'({holdActive, jogAllowed}), 32'h2);
    u_host_model.send("S");
    @(posedge clk_sys);
    lookaheadActive <= 1'b1;
    u_host_model.send("\\");
    check("reverse", 32'(reversalAllowed), 32'h1);
    u_host_model.send("R");
    @(posedge clk_sys);
    lookaheadActive <= 1'b0;
    motorsOpenLoop <= 9'($random(seed)) | 9'h001;
    u_host_model.send("A");
    rd("state", cmd_pkg::REG_STAT, 32'hF00, 32'h800);
    check("aborts", 32'(abortCnt), 32'h1);
    check("close", 32'(lastClose), 32'(motorsOpenLoop));
    check("ends", 32'({useOrigEnd, prejogToEnd}), 32'h3);
    u_host_model.send("P\015");
    check("orig", 32'(useOrigEnd), 32'h0);
    setCfg(4'h0, segT, 1'b1, 1'b0);
    u_host_model.send("RA");
    rd("state", cmd_pkg::REG_STAT, 32'hF00, 32'h800);
    check("ends", 32'({useOrigEnd, prejogToEnd}), 32'h0);
    u_host_model.send("B\015");
    check("radius", 32'(radiusAbs), 32'h0);
    u_host_model.send("B(X,R)\015");
    rd("motion", cmd_pkg::REG_MOTION, 32'h3FF, 32'h3FF);
    check("axis", 32'(axisAbs), 32'h1FF);
    @(posedge clk_sys);
    bufferOpen <= 1'b1;
    u_host_model.send("B(Y)\015");
    rd("motion", cmd_pkg::REG_MOTION, 32'h3FF, 32'h3FF);
    check("stored", 32'(storeCnt), 32'h1);
    end_sim();
  end
endmodule : card_cmd_ctrl_test
